//--- logic/pcsag_decode.sv
/*
  Instruction field decoder: splits a word into opcode and specifier,
  reports the byte flag and the operate-group class, registered.
  Assumes a word presented with a one-cycle load strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsag_decode (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Instruction in
  input wire logic i_load,
  input wire logic [15:0] i_word,
  // Fields out
  output pcsag_pkg::pcsag_decode_t o_dec
);
  pcsag_pkg::pcsag_decode_t dec_reg;
  pcsag_pkg::pcsag_decode_t dec_next;

  always_comb begin
    dec_next = dec_reg;
    if (i_load) begin
      dec_next.opcode_word = i_word;
      // see RULE10
      dec_next.opcode = i_word[pcsag_pkg::OPC_LSB +: pcsag_pkg::OPC_W];
      dec_next.mode = i_word[pcsag_pkg::MODE_LSB +: pcsag_pkg::FLD_W];
      dec_next.regnum = i_word[pcsag_pkg::REG_LSB +: pcsag_pkg::FLD_W];
      // see RULE7
      dec_next.byte_op = i_word[pcsag_pkg::BYTE_BIT];
      // see RULE8
      dec_next.operate_group = (i_word == pcsag_pkg::OPC_HALT) ||
        (i_word == pcsag_pkg::OPC_WAIT) || (i_word == pcsag_pkg::OPC_RTI) ||
        (i_word == pcsag_pkg::OPC_RESET) || (i_word == pcsag_pkg::OPC_RTT) ||
        (i_word == pcsag_pkg::OPC_NOP) || (i_word == pcsag_pkg::OPC_READ_PROCESSOR_TYPE);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign o_dec = dec_reg;

  property p_byte_flag;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_load |=> (o_dec.byte_op == $past(i_word[pcsag_pkg::BYTE_BIT]));
  endproperty
  a_byte_flag: assert property (p_byte_flag) // see RULE7
    else $error("byte flag not bit 15");

  property p_operate;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_load && i_word == pcsag_pkg::OPC_HALT) |=> o_dec.operate_group;
  endproperty
  a_operate: assert property (p_operate) // see RULE8
    else $error("halt not operate group");

  property p_spec;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_load |=> ({o_dec.mode, o_dec.regnum} ==
        $past(i_word[pcsag_pkg::SPEC_LSB +: pcsag_pkg::SPEC_W]));
  endproperty
  a_spec: assert property (p_spec) // see RULE10
    else $error("specifier field wrong");
endmodule
`default_nettype wire

//--- logic/pcsag_pkg.sv
/*
  Package for the operand-address generator: field positions, modes,
  register numbers, opcodes and the sequencer state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcsag_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_BIT = 15;
  localparam int unsigned SPEC_LSB = 0;
  localparam int unsigned SPEC_W = 6;
  localparam int unsigned REG_LSB = 0;
  localparam int unsigned MODE_LSB = 3;
  localparam int unsigned FLD_W = 3;
  localparam int unsigned OPC_LSB = 6;
  localparam int unsigned OPC_W = 10;
  localparam logic [2:0] MODE_AUTOINC = 3'h2;
  localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
  localparam logic [2:0] MODE_AUTODEC = 3'h4;
  localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_INDEX_DEF = 3'h7;
  localparam logic [2:0] REG_SP = 3'h6;
  localparam logic [2:0] REG_PC = 3'h7;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // Operate group codes: halt, wait, rti, reset, rtt, nop, read_processor_type
  localparam logic [15:0] OPC_HALT = 16'h0000;
  localparam logic [15:0] OPC_WAIT = 16'h0001;
  localparam logic [15:0] OPC_RTI = 16'h0002;
  localparam logic [15:0] OPC_RESET = 16'h0005;
  localparam logic [15:0] OPC_RTT = 16'h0006;
  localparam logic [15:0] OPC_READ_PROCESSOR_TYPE = 16'h0007;
  localparam logic [15:0] OPC_NOP = 16'h00A0;

  typedef enum logic [2:0] {
    PCSAG_IDLE = 3'h0,
    PCSAG_FETCH_INSN = 3'h1,
    PCSAG_FETCH_EXT = 3'h2,
    PCSAG_FETCH_IND = 3'h3,
    PCSAG_DONE = 3'h4
  } pcsag_state_t;

  typedef struct packed {
    logic [15:0] opcode_word;
    logic [9:0] opcode;
    logic [2:0] mode;
    logic [2:0] regnum;
    logic byte_op;
    logic operate_group;
  } pcsag_decode_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
    logic is_immediate;
    logic [15:0] pc;
    logic [15:0] sp;
  } pcsag_result_t;
endpackage

//--- logic/pcsag_top.sv
/*
  Operand-address generator for program-counter and stack-pointer
  addressing. Fetches the instruction and any extension words, steps
  the program counter, and forms the operand address.
  Assumes a memory that answers a read request with one-cycle valid
  data some cycles later, and only one read outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Mode 2 on the program counter is immediate: autoincrement via PC, operand is the next word.
// RULE2 - Immediate: fetch instruction, PC plus two, read operand at PC, PC plus two again.
// RULE3 - Mode 3 on PC reads the next word, steps PC by two, and uses the word as absolute address.
// RULE4 - Mode 6 on PC adds the offset word to the already advanced PC to form the address.
// RULE5 - Mode 7 on PC adds offset to updated PC and reads memory there for the address.
// RULE6 - Stack pointer autoincrement or autodecrement always steps by two, bytes too.
// RULE7 - Instruction bit 15 set means byte operation, clear means word.
// RULE8 - Operate-group instructions are a format with no operand specifier.
// RULE9 - Every word fetched through the PC adds two to the PC, byte data included.
// RULE10 - Single-operand format: bits 5..0 are specifier, upper bits the opcode.
module pcsag_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_start,
  input wire logic [15:0] i_pc,
  input wire logic [15:0] i_sp,
  input wire logic [15:0] i_reg_value,
  // Memory read port
  output logic o_rd_req,
  output logic [15:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  // Results
  output logic o_done,
  output logic o_operate,
  output logic o_byte_op,
  output logic [15:0] o_operand_addr,
  output logic [15:0] o_operand_data,
  output logic o_immediate,
  output logic [15:0] o_pc,
  output logic [15:0] o_sp
);
  typedef struct packed {
    pcsag_pkg::pcsag_state_t state;
    logic rd_req;
    logic [15:0] rd_addr;
    logic ptr_rd;
    logic done;
    pcsag_pkg::pcsag_result_t res;
  } pcsag_core_t;

  pcsag_core_t core_reg;
  pcsag_core_t core_next;
  pcsag_pkg::pcsag_decode_t dec;
  logic insn_load;
  logic pc_reg_sel;
  logic sp_reg_sel;

  assign insn_load = (core_reg.state == pcsag_pkg::PCSAG_FETCH_INSN) &&
    i_rd_valid;

  pcsag_decode u_decode (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_load(insn_load),
    .i_word(i_rd_data),
    .o_dec(dec)
  );

  assign pc_reg_sel = (dec.regnum == pcsag_pkg::REG_PC);
  assign sp_reg_sel = (dec.regnum == pcsag_pkg::REG_SP);

  always_comb begin
    core_next = core_reg;
    core_next.rd_req = 1'b0;
    core_next.done = 1'b0;
    unique case (core_reg.state)
      pcsag_pkg::PCSAG_IDLE: begin
        if (i_start) begin
          core_next.res = '0;
          core_next.res.pc = i_pc;
          core_next.res.sp = i_sp;
          core_next.rd_req = 1'b1;
          core_next.rd_addr = i_pc;
          core_next.ptr_rd = 1'b0;
          core_next.state = pcsag_pkg::PCSAG_FETCH_INSN;
        end
      end
      pcsag_pkg::PCSAG_FETCH_INSN: begin
        if (i_rd_valid) begin
          // see RULE2, see RULE9
          core_next.res.pc = core_reg.res.pc + pcsag_pkg::WORD_STEP;
          core_next.state = pcsag_pkg::PCSAG_FETCH_EXT;
        end
      end
      pcsag_pkg::PCSAG_FETCH_EXT: begin
        // Decoded fields valid here; PC-relative modes need one more word
        core_next.state = pcsag_pkg::PCSAG_DONE;
        core_next.done = 1'b1;
        if (dec.operate_group) begin
          core_next.res.valid = 1'b0;
        end else if (pc_reg_sel && dec.mode >= pcsag_pkg::MODE_AUTOINC &&
            dec.mode != pcsag_pkg::MODE_AUTODEC &&
            dec.mode != pcsag_pkg::MODE_AUTODEC_DEF) begin
          core_next.done = 1'b0;
          core_next.rd_req = 1'b1;
          core_next.rd_addr = core_reg.res.pc;
          core_next.state = pcsag_pkg::PCSAG_FETCH_IND;
          // Operand address of immediate is the word at PC, see RULE1
          core_next.res.addr = core_reg.res.pc;
        end else begin
          core_next.res.valid = 1'b1;
          core_next.res.addr = i_reg_value;
          if (sp_reg_sel && (dec.mode == pcsag_pkg::MODE_AUTODEC ||
              dec.mode == pcsag_pkg::MODE_AUTODEC_DEF)) begin
            // Push; step fixed at two, see RULE6
            core_next.res.sp = core_reg.res.sp - pcsag_pkg::WORD_STEP;
            core_next.res.addr = core_reg.res.sp - pcsag_pkg::WORD_STEP;
          end else if (sp_reg_sel && (dec.mode == pcsag_pkg::MODE_AUTOINC ||
              dec.mode == pcsag_pkg::MODE_AUTOINC_DEF)) begin
            // Pop; step fixed at two, see RULE6
            core_next.res.sp = core_reg.res.sp + pcsag_pkg::WORD_STEP;
            core_next.res.addr = core_reg.res.sp;
          end
        end
      end
      pcsag_pkg::PCSAG_FETCH_IND: begin
        if (i_rd_valid) begin
          // Second word fetched through PC, see RULE9
          core_next.res.pc = core_reg.res.pc + pcsag_pkg::WORD_STEP;
          core_next.res.valid = 1'b1;
          unique case (dec.mode)
            pcsag_pkg::MODE_AUTOINC: begin
              // see RULE1, see RULE2
              core_next.res.is_immediate = 1'b1;
              core_next.res.data = i_rd_data;
              core_next.done = 1'b1;
              core_next.state = pcsag_pkg::PCSAG_DONE;
            end
            pcsag_pkg::MODE_AUTOINC_DEF: begin
              // see RULE3
              core_next.res.addr = i_rd_data;
              core_next.done = 1'b1;
              core_next.state = pcsag_pkg::PCSAG_DONE;
            end
            pcsag_pkg::MODE_INDEX: begin
              // see RULE4
              core_next.res.addr = i_rd_data + core_reg.res.pc +
                pcsag_pkg::WORD_STEP;
              core_next.done = 1'b1;
              core_next.state = pcsag_pkg::PCSAG_DONE;
            end
            default: begin
              // Deferred: read pointer at sum, see RULE5
              core_next.ptr_rd = 1'b1;
              core_next.rd_req = 1'b1;
              core_next.rd_addr = i_rd_data + core_reg.res.pc +
                pcsag_pkg::WORD_STEP;
              core_next.state = pcsag_pkg::PCSAG_FETCH_EXT;
              core_next.res.valid = 1'b0;
            end
          endcase
        end
      end
      pcsag_pkg::PCSAG_DONE: begin
        core_next.state = pcsag_pkg::PCSAG_IDLE;
      end
      default: begin
        core_next.state = pcsag_pkg::PCSAG_IDLE;
      end
    endcase
    // Pointer read of relative-deferred waits here; a flag, not an
    // address compare, so a zero offset or zero sum still works
    if (core_reg.state == pcsag_pkg::PCSAG_FETCH_EXT &&
        core_reg.ptr_rd) begin
      core_next = core_reg;
      core_next.rd_req = 1'b0;
      core_next.done = 1'b0;
      if (i_rd_valid) begin
        // Extra indirection, see RULE5
        core_next.res.addr = i_rd_data;
        core_next.res.valid = 1'b1;
        core_next.ptr_rd = 1'b0;
        core_next.done = 1'b1;
        core_next.state = pcsag_pkg::PCSAG_DONE;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // Registered decode flags are taken straight from the decoder flops
  assign o_rd_req = core_reg.rd_req;
  assign o_rd_addr = core_reg.rd_addr;
  assign o_done = core_reg.done;
  assign o_operate = dec.operate_group;
  assign o_byte_op = dec.byte_op;
  assign o_operand_addr = core_reg.res.addr;
  assign o_operand_data = core_reg.res.data;
  assign o_immediate = core_reg.res.is_immediate;
  assign o_pc = core_reg.res.pc;
  assign o_sp = core_reg.res.sp;

  sequence s_insn_back;
    core_reg.state == pcsag_pkg::PCSAG_FETCH_INSN && i_rd_valid;
  endsequence

  property p_pc_step;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_insn_back |=> (o_pc == $past(o_pc) + pcsag_pkg::WORD_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step) // see RULE9
    else $error("pc not stepped by two");

  property p_sp_step;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (core_reg.state == pcsag_pkg::PCSAG_FETCH_EXT && sp_reg_sel &&
       !dec.operate_group && dec.mode == pcsag_pkg::MODE_AUTODEC) |=>
      (o_sp == $past(o_sp) - pcsag_pkg::WORD_STEP);
  endproperty
  a_sp_step: assert property (p_sp_step) // see RULE6
    else $error("sp not stepped by two");

  property p_imm;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (core_reg.state == pcsag_pkg::PCSAG_FETCH_IND && i_rd_valid &&
       dec.mode == pcsag_pkg::MODE_AUTOINC) |=>
      (o_done && o_immediate && o_operand_data == $past(i_rd_data));
  endproperty
  a_imm: assert property (p_imm) // see RULE1
    else $error("immediate operand wrong");

  property p_abs;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (core_reg.state == pcsag_pkg::PCSAG_FETCH_IND && i_rd_valid &&
       dec.mode == pcsag_pkg::MODE_AUTOINC_DEF) |=>
      (o_done && o_operand_addr == $past(i_rd_data));
  endproperty
  a_abs: assert property (p_abs) // see RULE3
    else $error("absolute address wrong");

  property p_rel;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (core_reg.state == pcsag_pkg::PCSAG_FETCH_IND && i_rd_valid &&
       dec.mode == pcsag_pkg::MODE_INDEX) |=> (o_operand_addr == o_pc +
       $past(i_rd_data));
  endproperty
  a_rel: assert property (p_rel) // see RULE4
    else $error("relative address wrong");

  property p_imm_pc;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (o_done && o_immediate) |-> (o_pc == o_operand_addr +
       pcsag_pkg::WORD_STEP);
  endproperty
  a_imm_pc: assert property (p_imm_pc) // see RULE2
    else $error("pc not past immediate");

  property p_reldef;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (core_reg.state == pcsag_pkg::PCSAG_FETCH_IND && i_rd_valid &&
       dec.mode == pcsag_pkg::MODE_INDEX_DEF) |=>
      (o_rd_req && !o_done);
  endproperty
  a_reldef: assert property (p_reldef) // see RULE5
    else $error("no indirect read");
endmodule
`default_nettype wire

//--- verif/pc_sp_operand_address_gen_test.sv
/*
  Self-checking bench for the operand-address generator: random and
  hand-picked PC and SP specifiers, operate codes, a refused start.
  Assumes the memory model alongside and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module pc_sp_operand_address_gen_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000;
  logic [15:0] regv = 16'h0000;
  logic [3:0] lat = 4'h1;
  logic rd_req, rd_valid, done, operate, byte_op, imm;
  logic [15:0] rd_addr, rd_data, op_addr, op_data, pc_o, sp_o;
  logic [15:0] rd_q [$];
  int errors = 0;
  int checked = 0;
  logic [15:0] ops [8] = '{pcsag_pkg::OPC_HALT, pcsag_pkg::OPC_WAIT,
    pcsag_pkg::OPC_RTI, pcsag_pkg::OPC_RESET, pcsag_pkg::OPC_RTT,
    pcsag_pkg::OPC_READ_PROCESSOR_TYPE, pcsag_pkg::OPC_NOP, 16'h00A1};
  logic [5:0] specs [6] = '{6'h17, 6'h1F, 6'h37, 6'h3F, 6'h16, 6'h26};

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rd_req === 1'b1) begin
      rd_q.push_back(rd_addr);
    end
  end

  pcsag_top u_dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_start(start),
    .i_pc(pc_in), .i_sp(sp_in), .i_reg_value(regv), .o_rd_req(rd_req),
    .o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_done(done), .o_operate(operate), .o_byte_op(byte_op),
    .o_operand_addr(op_addr), .o_operand_data(op_data),
    .o_immediate(imm), .o_pc(pc_o), .o_sp(sp_o));
  pcsag_mem_model u_mem (.i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_latency(lat));

  task automatic wrap_up;
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic pcsag_pkg::pcsag_result_t expect_of(
    input logic [15:0] insn, input logic [15:0] pcv,
    input logic [15:0] spv, input logic [15:0] ext,
    input logic [15:0] ind, input logic opr);
    pcsag_pkg::pcsag_result_t r;
    logic [2:0] md;
    md = insn[5:3];
    r = '0;
    r.sp = spv;
    r.pc = pcv + pcsag_pkg::WORD_STEP;
    r.data = ext;
    // Operate codes carry no specifier, so low bits never touch PC or SP
    if (!opr && insn[2:0] == pcsag_pkg::REG_PC) begin
      r.pc = r.pc + pcsag_pkg::WORD_STEP;
      r.is_immediate = (md == pcsag_pkg::MODE_AUTOINC);
      r.valid = !r.is_immediate;
      if (md == pcsag_pkg::MODE_AUTOINC_DEF) begin
        r.addr = ext;
      end else if (md == pcsag_pkg::MODE_INDEX) begin
        r.addr = ext + r.pc;
      end else begin
        r.addr = ind;
      end
    end else if (!opr && insn[2:0] == pcsag_pkg::REG_SP) begin
      r.valid = 1'b1;
      if (md == pcsag_pkg::MODE_AUTOINC) begin
        r.addr = spv;
        r.sp = spv + pcsag_pkg::WORD_STEP;
      end else begin
        r.sp = spv - pcsag_pkg::WORD_STEP;
        r.addr = r.sp;
      end
    end
    return r;
  endfunction

  task automatic run(input logic [15:0] insn, input logic [15:0] pcv,
    input logic [15:0] spv, input logic [15:0] ext,
    input logic [15:0] ind, input logic is_opr, input logic [3:0] l);
    pcsag_pkg::pcsag_result_t e;
    logic [15:0] sum;
    int n;
    int k;
    e = expect_of(insn, pcv, spv, ext, ind, is_opr);
    sum = ext + pcv + 16'h0004;
    n = 1;
    if (!is_opr && insn[2:0] == pcsag_pkg::REG_PC) begin
      n = (insn[5:3] == pcsag_pkg::MODE_INDEX_DEF) ? 3 : 2;
    end
    u_mem.mem[pcv[15:1]] = insn;
    u_mem.mem[pcv[15:1] + 15'h0001] = ext;
    if (n == 3) begin
      u_mem.mem[sum[15:1]] = ind;
    end
    rd_q.delete();
    @(posedge sys_clk);
    start <= 1'b1;
    pc_in <= pcv;
    sp_in <= spv;
    regv <= 16'($urandom);
    lat <= l;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    // A start while busy must be ignored
    start <= 1'b1;
    pc_in <= ~pcv;
    @(posedge sys_clk);
    start <= 1'b0;
    for (k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      if (done === 1'b1) begin
        break;
      end
    end
    if (k == 300) begin
      errors++;
      wrap_up();
    end
    `CHK("o_pc", e.pc, pc_o);
    `CHK("o_sp", e.sp, sp_o);
    `CHK("o_byte_op", insn[15], byte_op);
    `CHK("o_operate", is_opr, operate);
    `CHK("o_immediate", e.is_immediate, imm);
    if (e.is_immediate) begin
      `CHK("o_operand_data", ext, op_data);
    end
    if (e.valid && !is_opr) begin
      `CHK("o_operand_addr", e.addr, op_addr);
    end
    `CHK("read count", n, rd_q.size());
    if (rd_q.size() == n) begin
      `CHK("read insn", pcv, rd_q[0]);
      if (n > 1) begin
        `CHK("read ext", pcv + 16'h0002, rd_q[1]);
      end
      if (n > 2) begin
        `CHK("read ind", sum, rd_q[2]);
      end
    end
    @(posedge sys_clk);
    @(posedge sys_clk);
  endtask

  initial begin
    logic [15:0] w;
    logic [15:0] p;
    void'($urandom(28));
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    // Every specifier twice; even entries word form on fastest memory, odd entries byte form on slow
    for (int i = 0; i < 12; i++) begin
      w = {i[0], 9'h0A5, specs[i % 6]};
      run(w, 16'h1000, 16'h0400, 16'h9002, 16'h2468, 1'b0, 4'(1 + 14 * (i % 2)));
    end
    run(16'h15D7, 16'hFFFC, 16'h0000, 16'h7E7E, 16'h0000, 1'b0, 4'h2);
    run(16'h0A26, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 1'b0, 4'h1);
    for (int i = 0; i < 8; i++) begin
      run(ops[i], 16'h0100, 16'h0800, 16'h0000, 16'h0000, i < 7, 4'h3);
    end
    for (int i = 0; i < 60; i++) begin
      w = {16'($urandom) & 16'hFFC0} | {10'h000, specs[$urandom_range(0, 5)]};
      p = {2'b00, 12'($urandom), 2'b00};
      run(w, p, {15'($urandom), 1'b0}, {2'b10, 13'($urandom), 1'b0},
        16'($urandom), 1'b0, 4'($urandom_range(1, 6)));
    end
    wrap_up();
  end
endmodule
`default_nettype wire

//--- verif/pcsag_mem_model.sv
/*
  Memory model for the operand-address generator: one read at a time,
  answer after a delay set by the bench.
  Assumes a request pulse with a stable address on the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsag_mem_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Read port
  input wire logic i_rd_req,
  input wire logic [15:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  // Answer delay in cycles, at least one
  input wire logic [3:0] i_latency
);
  logic [15:0] mem [0:32767];
  logic [15:0] addr_reg;
  logic [3:0] wait_reg;
  logic busy_reg;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      addr_reg <= 16'h0000;
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'hA5A5;
    end else begin
      o_rd_valid <= 1'b0;
      // Data is not held past its valid cycle
      o_rd_data <= ~o_rd_data;
      if (i_rd_req) begin
        busy_reg <= 1'b1;
        addr_reg <= i_rd_addr;
        wait_reg <= i_latency - 4'h1;
      end else if (busy_reg) begin
        if (wait_reg == 4'h0) begin
          o_rd_valid <= 1'b1;
          o_rd_data <= mem[addr_reg[15:1]];
          busy_reg <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire
